// >>> csfp_pkg.sv
// Shared constants, types and helpers of the serial frame port.
package csfp_pkg;
  localparam int WORD_W = 16;
  localparam int FRAME_BITS = 16;
  localparam int FRAME_SMALL = 256;
  localparam int FRAME_LARGE = 512;
  localparam int CNT_W = 10;
  localparam int BIT_CNT_W = 5;
  localparam int NUM_REGS = 5;
  localparam int REG_W = 8;
  localparam int ADDR_W = 3;
  localparam int REQ_BIT = 0;
  localparam int ADDR_LSB = 9;
  localparam int RD_BIT = 12;
  localparam int MS_BIT = 15;
  localparam int DIV_W = 8;
  localparam int SCLK_DIV = 1;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_PRI,
    FR_SEC
  } csfp_frame_t;

  // Shift clocks between primary frame starts
  function automatic logic [CNT_W-1:0] frame_len(input logic big);
    return big ? CNT_W'(FRAME_LARGE) : CNT_W'(FRAME_SMALL);
  endfunction

  function automatic logic reg_ok(input logic [ADDR_W-1:0] addr);
    return 32'(addr) < NUM_REGS;
  endfunction
endpackage

// >>> csfp_link_if.sv
// Pins between converter and host, with wire resolution.
`timescale 1ns/1ps
`default_nettype none
interface csfp_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic sclk;
  logic dev_fs_o;
  logic dev_fs_oe;
  logic host_fs_o;
  logic host_fs_oe;
  logic fs;
  logic frame_sync_delayed;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  logic fc;

  // Undriven shift clock idles low, frame sync idles high
  assign sclk = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);
  assign fs = dev_fs_oe ? dev_fs_o : (host_fs_oe ? host_fs_o : 1'b1);
  assign dout = dout_oe ? dout_o : 1'b0;

  modport dev (
    input sclk, fs, din, fc,
    output dev_sclk_o, dev_sclk_oe, dev_fs_o, dev_fs_oe, frame_sync_delayed, dout_o, dout_oe
  );
  modport host (
    input sclk, fs, frame_sync_delayed, dout, dout_oe,
    output host_sclk_o, host_sclk_oe, host_fs_o, host_fs_oe, din, fc
  );
endinterface
`default_nettype wire

// >>> csfp_host.sv
// Host end of the serial frame port.
`timescale 1ns/1ps
`default_nettype none
module csfp_host #(
  parameter int SCLK_DIV = csfp_pkg::SCLK_DIV
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic host_master_i,
  input wire logic frame_large_i,
  input wire logic [csfp_pkg::WORD_W-1:0] dac_sample_i,
  input wire logic dac_valid_i,
  output logic [csfp_pkg::WORD_W-1:0] adc_sample_o,
  output logic adc_sec_o,
  output logic adc_valid_o,
  input wire logic [csfp_pkg::WORD_W-1:0] ctl_word_i,
  input wire logic ctl_valid_i,
  output logic ctl_ready_o,
  output logic ctl_done_o,
  csfp_link_if.host lnk
);
  localparam int W = csfp_pkg::WORD_W;
  localparam int CW = csfp_pkg::CNT_W;
  localparam logic [CW-1:0] BITS_C = CW'(csfp_pkg::FRAME_BITS);

  typedef struct packed {
    logic [csfp_pkg::DIV_W-1:0] div;
    logic sclk;
    logic [2:0] rxt;
    logic [2:0] dnt;
    logic [W-1:0] adc;
    logic sec;
    logic av;
    logic [W-1:0] dac;
    logic txt;
    logic [W-1:0] ctl;
    logic ct;
    logic busy;
    logic done;
    logic rs;
  } csfp_host_sys_t;

  typedef struct packed {
    logic [1:0] rst;
    logic [1:0] ms;
    logic [1:0] big;
    logic [2:0] txt;
    logic [2:0] ct;
    logic [W-1:0] hold;
    logic pend;
    logic req;
    logic [CW-1:0] cnt;
    logic fs;
    logic sec;
    logic [W-1:0] sh;
  } csfp_host_pos_t;

  typedef struct packed {
    logic [csfp_pkg::BIT_CNT_W-1:0] bc;
    logic [W-1:0] sh;
    csfp_pkg::csfp_frame_t kind;
    logic pend;
    logic [W-1:0] rx_word;
    logic rx_sec;
    logic rx_tgl;
    logic dn_tgl;
  } csfp_host_neg_t;

  csfp_host_sys_t s_q, s_d;
  csfp_host_pos_t p_q, p_d;
  csfp_host_neg_t n_q, n_d;
  logic lrst;
  logic mst;
  logic fs_in;
  logic [CW-1:0] len;
  logic [CW-1:0] half;
  logic sec_go;
  logic [W-1:0] w;

  assign lrst = p_q.rst[1];
  assign mst = p_q.ms[1];
  assign fs_in = lnk.fs;

  always_comb begin
    s_d = s_q;
    s_d.av = 1'b0;
    s_d.done = 1'b0;
    s_d.rxt = {s_q.rxt[1:0], n_q.rx_tgl};
    s_d.dnt = {s_q.dnt[1:0], n_q.dn_tgl};
    if (s_q.rxt[2] ^ s_q.rxt[1]) begin
      s_d.adc = n_q.rx_word;
      s_d.sec = n_q.rx_sec;
      s_d.av = 1'b1;
    end
    if (s_q.dnt[2] ^ s_q.dnt[1]) begin
      s_d.done = 1'b1;
      s_d.busy = 1'b0;
    end
    if (dac_valid_i) begin
      s_d.dac = dac_sample_i;
      s_d.txt = ~s_q.txt;
    end
    if (ctl_valid_i && !s_q.busy) begin
      s_d.ctl = ctl_word_i;
      s_d.ct = ~s_q.ct;
      s_d.busy = 1'b1;
    end
    // Host makes the shift clock only when the converter is slave
    if (host_master_i) begin
      if (s_q.div == csfp_pkg::DIV_W'(SCLK_DIV - 1)) begin
        s_d.div = '0;
        s_d.sclk = ~s_q.sclk;
      end else begin
        s_d.div = s_q.div + 1'b1;
      end
    end else begin
      s_d.div = '0;
      s_d.sclk = 1'b0;
    end
    if (srst_i) begin
      s_d = '0;
      s_d.rs = 1'b1;
      // Clock keeps toggling in reset so the link side sees the reset too
      if (s_q.rs && host_master_i) begin
        s_d.sclk = ~s_q.sclk;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_q <= s_d;
  end

  always_comb begin
    p_d = p_q;
    p_d.rst = {p_q.rst[0], srst_i};
    p_d.ms = {p_q.ms[0], host_master_i};
    p_d.big = {p_q.big[0], frame_large_i};
    p_d.txt = {p_q.txt[1:0], s_q.txt};
    p_d.ct = {p_q.ct[1:0], s_q.ct};
    if (p_q.txt[2] ^ p_q.txt[1]) begin
      p_d.hold = s_q.dac;
    end
    if (p_q.ct[2] ^ p_q.ct[1]) begin
      p_d.pend = 1'b1;
    end
    len = csfp_pkg::frame_len(p_q.big[1]);
    half = len >> 1;
    sec_go = (p_q.cnt == half) ? n_q.pend : p_q.sec;
    p_d.cnt = (p_q.cnt == len - 1'b1) ? '0 : p_q.cnt + 1'b1;
    // Fixed frame spacing, secondary frame only when requested
    p_d.fs = !(p_q.cnt < BITS_C ||
      (p_q.cnt >= half && p_q.cnt < CW'(half + BITS_C) && sec_go));
    p_d.sec = sec_go && p_q.cnt >= half && p_q.cnt < CW'(half + BITS_C - 1'b1);
    if (!fs_in) begin
      p_d.sh = {p_q.sh[W-2:0], 1'b0};
    end else if (n_q.pend) begin
      p_d.sh = s_q.ctl;
      p_d.pend = 1'b0;
      p_d.req = 1'b0;
    end else begin
      // Request bit only changes between frames
      p_d.req = p_q.pend;
      p_d.sh = {p_q.hold[W-1:1], p_q.pend};
    end
    if (lrst || !mst) begin
      p_d.cnt = '0;
      p_d.fs = 1'b1;
      p_d.sec = 1'b0;
    end
    if (lrst) begin
      p_d.hold = '0;
      p_d.pend = 1'b0;
      p_d.req = 1'b0;
      p_d.sh = '0;
    end
  end

  always_ff @(posedge sclk_i) begin
    p_q <= p_d;
  end

  always_comb begin
    n_d = n_q;
    w = {n_q.sh[W-2:0], lnk.dout};
    if (!fs_in) begin
      if (32'(n_q.bc) < csfp_pkg::FRAME_BITS) begin
        n_d.sh = w;
        n_d.bc = n_q.bc + 1'b1;
      end
      if (n_q.bc == '0) begin
        n_d.kind = n_q.pend ? csfp_pkg::FR_SEC : csfp_pkg::FR_PRI;
      end
      if (32'(n_q.bc) == csfp_pkg::FRAME_BITS - 1) begin
        n_d.rx_word = w;
        n_d.rx_tgl = ~n_q.rx_tgl;
        case (n_q.kind)
          csfp_pkg::FR_PRI: begin
            n_d.rx_sec = 1'b0;
            n_d.pend = p_q.req;
          end
          csfp_pkg::FR_SEC: begin
            n_d.rx_sec = 1'b1;
            n_d.pend = 1'b0;
            n_d.dn_tgl = ~n_q.dn_tgl;
          end
          default: begin
          end
        endcase
      end
    end else begin
      n_d.bc = '0;
      n_d.kind = csfp_pkg::FR_IDLE;
    end
    if (lrst) begin
      n_d = '0;
    end
  end

  always_ff @(negedge sclk_i) begin
    n_q <= n_d;
  end

  assign lnk.host_sclk_o = s_q.sclk;
  assign lnk.host_sclk_oe = host_master_i;
  assign lnk.host_fs_o = p_q.fs;
  assign lnk.host_fs_oe = mst;
  assign lnk.din = p_q.sh[W-1];
  assign lnk.fc = p_q.req;
  assign adc_sample_o = s_q.adc;
  assign adc_sec_o = s_q.sec;
  assign adc_valid_o = s_q.av;
  assign ctl_ready_o = !s_q.busy;
  assign ctl_done_o = s_q.done;
endmodule
`default_nettype wire

// >>> csfp_dev.sv
// Converter end of the serial frame port, link logic on the shift clock.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Frame mode from both mode pins
// - Master when select high, slave when low
// - Master shift clock is frame rate times 256/512
// - Slave shift clock supplied synchronous from outside
// - Data shifts only inside the frame-sync interval
// - Power-down disables port, keeps registers
// - Power-down clears counters; resume needs no setup
// - Reset loads every register default
// - Sixteen shift clocks from frame-sync fall
// - Primary moves both sample words together
// - Secondary carries control in, read data out
// - Only frame-sync falling edge starts a frame
// - Primary starts fixed 256 or 512 clocks apart
// - Internal timing derived from master clock
// - Output bits on rising edge, released outside
// - Master drives frame sync low during transfer
// - Delayed frame sync in master mode only, same pulse length
// - Input bits sampled on falling edges
module csfp_dev #(
  parameter int SCLK_DIV = csfp_pkg::SCLK_DIV
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic master_sel_i,
  input wire logic frame_mode_sel_lo_i,
  input wire logic frame_mode_sel_hi_i,
  input wire logic power_down_n_i,
  input wire logic [csfp_pkg::WORD_W-1:0] adc_sample_i,
  input wire logic adc_valid_i,
  output logic [csfp_pkg::WORD_W-1:0] dac_sample_o,
  output logic dac_valid_o,
  csfp_link_if.dev lnk
);
  localparam int W = csfp_pkg::WORD_W;
  localparam int CW = csfp_pkg::CNT_W;
  localparam int B = csfp_pkg::FRAME_BITS;
  localparam logic [CW-1:0] BITS_C = CW'(B);

  typedef struct packed {
    logic [1:0] ms;
    logic [1:0] pd;
    logic [csfp_pkg::DIV_W-1:0] div;
    logic sclk;
    logic [2:0] rxt;
    logic [W-1:0] dac;
    logic dv;
    logic [W-1:0] adc;
    logic txt;
    logic rs;
  } csfp_dev_sys_t;

  typedef struct packed {
    logic [1:0] rst;
    logic [1:0] ms;
    logic [1:0] pd;
    logic [1:0] lo;
    logic [1:0] hi;
    logic [1:0] fc;
    logic [2:0] txt;
    logic [W-1:0] hold;
    logic [CW-1:0] cnt;
    logic fs;
    logic sec;
    logic [B-1:0] frame_sync_delayed;
    logic [W-1:0] sh;
    logic arm;
  } csfp_dev_pos_t;

  typedef struct packed {
    logic [csfp_pkg::BIT_CNT_W-1:0] bc;
    logic [W-1:0] sh;
    csfp_pkg::csfp_frame_t kind;
    logic pend;
    logic [csfp_pkg::NUM_REGS-1:0][csfp_pkg::REG_W-1:0] regs;
    logic rdv;
    logic [csfp_pkg::ADDR_W-1:0] rda;
    logic [W-1:0] rx_word;
    logic rx_tgl;
  } csfp_dev_neg_t;

  csfp_dev_sys_t s_q, s_d;
  csfp_dev_pos_t p_q, p_d;
  csfp_dev_neg_t n_q, n_d;
  logic lrst;
  logic run;
  logic mst;
  logic fs_in;
  logic [CW-1:0] len;
  logic [CW-1:0] half;
  logic sec_go;
  logic [W-1:0] sw;
  logic [W-1:0] w;
  logic [csfp_pkg::ADDR_W-1:0] wa;

  assign lrst = p_q.rst[1];
  assign mst = p_q.ms[1];
  // Power-down stops the port but no register is touched
  assign run = !lrst && p_q.pd[1];
  // Frame sync is synchronous to the shift clock, so it is read directly
  assign fs_in = lnk.fs;

  // Master-clock side: shift-clock divider and sample word crossings
  always_comb begin
    s_d = s_q;
    s_d.ms = {s_q.ms[0], master_sel_i};
    s_d.pd = {s_q.pd[0], power_down_n_i};
    s_d.rxt = {s_q.rxt[1:0], n_q.rx_tgl};
    s_d.dv = 1'b0;
    if (s_q.rxt[2] ^ s_q.rxt[1]) begin
      s_d.dac = n_q.rx_word;
      s_d.dv = 1'b1;
    end
    if (adc_valid_i) begin
      s_d.adc = adc_sample_i;
      s_d.txt = ~s_q.txt;
    end
    // Shift clock from the master clock, stopped in power-down
    // Keeps running until the link side has seen power-down and closed the frame
    if (s_q.ms[1] && (s_q.pd[1] || p_q.pd[1] || !p_q.fs)) begin
      if (s_q.div == csfp_pkg::DIV_W'(SCLK_DIV - 1)) begin
        s_d.div = '0;
        s_d.sclk = ~s_q.sclk;
      end else begin
        s_d.div = s_q.div + 1'b1;
      end
    end else begin
      s_d.div = '0;
      s_d.sclk = 1'b0;
    end
    if (srst_i) begin
      s_d = '0;
      s_d.rs = 1'b1;
      s_d.ms = {s_q.ms[0], master_sel_i};
      // Clock keeps toggling in reset so the link side sees the reset too
      if (s_q.rs && s_q.ms[1]) begin
        s_d.sclk = ~s_q.sclk;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_q <= s_d;
  end

  // Rising shift-clock edge: frame generation and transmit shifter
  always_comb begin
    p_d = p_q;
    p_d.rst = {p_q.rst[0], srst_i};
    p_d.ms = {p_q.ms[0], master_sel_i};
    p_d.pd = {p_q.pd[0], power_down_n_i};
    p_d.lo = {p_q.lo[0], frame_mode_sel_lo_i};
    p_d.hi = {p_q.hi[0], frame_mode_sel_hi_i};
    p_d.fc = {p_q.fc[0], lnk.fc};
    p_d.txt = {p_q.txt[1:0], s_q.txt};
    if (p_q.txt[2] ^ p_q.txt[1]) begin
      p_d.hold = s_q.adc;
    end
    // High mode pin selects the long frame of a big cascade
    len = csfp_pkg::frame_len(p_q.hi[1]);
    half = len >> 1;
    sec_go = (p_q.cnt == half) ? n_q.pend : p_q.sec;
    p_d.cnt = (p_q.cnt == len - 1'b1) ? '0 : p_q.cnt + 1'b1;
    // Low for exactly sixteen clocks per frame
    p_d.fs = !(p_q.cnt < BITS_C ||
      (p_q.cnt >= half && p_q.cnt < CW'(half + BITS_C) && sec_go));
    p_d.sec = sec_go && p_q.cnt >= half && p_q.cnt < CW'(half + BITS_C - 1'b1);
    // Sixteen-clock delay lets the next device take the following slot
    p_d.frame_sync_delayed = {p_q.frame_sync_delayed[B-2:0], p_q.fs};
    sw = '0;
    sw[csfp_pkg::MS_BIT] = mst;
    if (n_q.rdv) begin
      sw[csfp_pkg::RD_BIT] = 1'b1;
      sw[csfp_pkg::ADDR_LSB +: csfp_pkg::ADDR_W] = n_q.rda;
      sw[csfp_pkg::REG_W-1:0] = n_q.regs[n_q.rda];
    end
    if (!fs_in) begin
      p_d.sh = {p_q.sh[W-2:0], 1'b0};
    end else begin
      // Word chosen while idle, so the first bit is ready at the fall
      p_d.sh = n_q.pend ? sw : p_q.hold;
    end
    // Only frames that start while running are answered
    if (fs_in) begin
      p_d.arm = 1'b1;
    end
    if (!run) begin
      p_d.arm = 1'b0;
    end
    if (!run || !mst) begin
      p_d.cnt = '0;
      p_d.fs = 1'b1;
      p_d.sec = 1'b0;
      p_d.frame_sync_delayed = '1;
    end
    if (lrst) begin
      p_d.hold = '0;
      p_d.sh = '0;
    end
  end

  always_ff @(posedge sclk_i) begin
    p_q <= p_d;
  end

  // Falling shift-clock edge: receive shifter and register file
  always_comb begin
    n_d = n_q;
    w = {n_q.sh[W-2:0], lnk.din};
    wa = w[csfp_pkg::ADDR_LSB +: csfp_pkg::ADDR_W];
    if (!fs_in) begin
      // Extra clocks past the sixteenth are ignored
      if (32'(n_q.bc) < B) begin
        n_d.sh = w;
        n_d.bc = n_q.bc + 1'b1;
      end
      if (n_q.bc == '0) begin
        n_d.kind = n_q.pend ? csfp_pkg::FR_SEC : csfp_pkg::FR_PRI;
      end
      if (32'(n_q.bc) == B - 1) begin
        case (n_q.kind)
          csfp_pkg::FR_PRI: begin
            n_d.rx_word = w;
            n_d.rx_tgl = ~n_q.rx_tgl;
            // Software bit, or hardware pin when the low mode pin allows it
            n_d.pend = w[csfp_pkg::REQ_BIT] | (p_q.lo[1] & p_q.fc[1]);
          end
          csfp_pkg::FR_SEC: begin
            n_d.pend = 1'b0;
            // Read answer goes out in the next secondary frame
            n_d.rdv = w[csfp_pkg::RD_BIT] && csfp_pkg::reg_ok(wa);
            n_d.rda = wa;
            if (!w[csfp_pkg::RD_BIT] && csfp_pkg::reg_ok(wa) && wa != '0) begin
              n_d.regs[wa] = w[csfp_pkg::REG_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      n_d.bc = '0;
      n_d.kind = csfp_pkg::FR_IDLE;
    end
    if (!run) begin
      n_d.bc = '0;
      n_d.kind = csfp_pkg::FR_IDLE;
      n_d.pend = 1'b0;
    end
    if (lrst) begin
      n_d = '0;
      for (int i = 0; i < csfp_pkg::NUM_REGS; i++) begin
        n_d.regs[i] = csfp_pkg::REG_RESET;
      end
    end
  end

  always_ff @(negedge sclk_i) begin
    n_q <= n_d;
  end

  assign lnk.dev_sclk_o = s_q.sclk;
  assign lnk.dev_sclk_oe = s_q.ms[1];
  assign lnk.dev_fs_o = p_q.fs;
  assign lnk.dev_fs_oe = mst;
  assign lnk.frame_sync_delayed = p_q.frame_sync_delayed[B-1];
  assign lnk.dout_o = p_q.sh[W-1];
  assign lnk.dout_oe = run && p_q.arm && !fs_in;
  assign dac_sample_o = s_q.dac;
  assign dac_valid_o = s_q.dv;
endmodule
`default_nettype wire

// >>> csfp_monitor.sv
// Protocol checker for the link between converter and host.
`timescale 1ns/1ps
`default_nettype none
module csfp_monitor (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic power_down_n_i,
  input wire logic sclk,
  input wire logic fs,
  input wire logic frame_sync_delayed,
  input wire logic dout_oe,
  input wire logic dev_fs_o,
  input wire logic dev_fs_oe,
  input wire logic host_fs_oe,
  input wire logic dev_sclk_oe,
  input wire logic host_sclk_oe
);
  logic quiet;
  logic fall;
  logic fs_q, fs_ok_q, fsd_ok_q, gap_ok_q;
  logic [4:0] low_q, fsdl_q;
  logic [9:0] gap_q;
  assign quiet = srst_i | ~power_down_n_i;
  assign fall = fs_q & ~fs;

  // Ok flags skip the partial frame seen right after reset or wake-up
  always_ff @(posedge sclk) begin
    if (quiet) begin
      fs_q <= 1'b1;
      fs_ok_q <= 1'b0;
      fsd_ok_q <= 1'b0;
      gap_ok_q <= 1'b0;
      low_q <= 5'h00;
      fsdl_q <= 5'h00;
      gap_q <= 10'h000;
    end else begin
      fs_q <= fs;
      fs_ok_q <= fs_ok_q | fs;
      fsd_ok_q <= fsd_ok_q | frame_sync_delayed;
      gap_ok_q <= gap_ok_q | fall;
      low_q <= fs ? 5'h00 : low_q + 5'h01;
      fsdl_q <= frame_sync_delayed ? 5'h00 : fsdl_q + 5'h01;
      gap_q <= fall ? 10'h001 : gap_q + 10'h001;
    end
  end

  a_oe_in_frame: assert property (@(posedge sclk) disable iff (quiet)
    dout_oe |-> !fs) else $error("serial output driven outside frame");
  a_oe_at_start: assert property (@(posedge sclk) disable iff (quiet)
    $rose(dout_oe) |-> fall) else $error("serial output enabled without frame start");
  a_frame_sixteen: assert property (@(posedge sclk) disable iff (quiet)
    (fs && !fs_q && fs_ok_q) |-> low_q == 5'h10) else $error("frame sync low length wrong");
  a_fsd_width: assert property (@(posedge sclk) disable iff (quiet)
    (frame_sync_delayed && fsdl_q != 5'h00 && fsd_ok_q) |-> fsdl_q == 5'h10)
    else $error("delayed sync low length wrong");
  a_fsd_delay: assert property (@(posedge sclk) disable iff (quiet)
    (dev_fs_oe && fall) |-> ##16 $fell(frame_sync_delayed)) else $error("delayed sync not 16 clocks late");
  a_frame_gap: assert property (@(posedge sclk) disable iff (quiet)
    (fall && gap_ok_q) |-> (gap_q == 10'h080 || gap_q == 10'h100 || gap_q == 10'h200))
    else $error("frame start spacing wrong");
  a_fs_one_owner: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(dev_fs_oe && host_fs_oe)) else $error("both ends drive frame sync");
  a_sclk_one_owner: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(dev_sclk_oe && host_sclk_oe)) else $error("both ends drive shift clock");
  a_pd_silent: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !power_down_n_i [*8] |-> !dout_oe && (dev_fs_o || !dev_fs_oe))
    else $error("port active in power-down");

  c_secondary: cover property (@(posedge sclk) disable iff (quiet) fall && gap_q == 10'h080);
  c_large: cover property (@(posedge sclk) disable iff (quiet) fall && gap_q == 10'h200);
  c_pd: cover property (@(posedge sys_clk_i) !power_down_n_i [*8]);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench joining both ends of the serial frame port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic srst, ms_sel, mode_lo, mode_hi, pd_n, arm, pend;
  logic [15:0] adc_in, dac_in, ctl_word, dac_out, adc_out;
  logic adc_in_valid, dac_in_valid, ctl_valid, dac_out_valid, adc_out_valid, adc_out_sec;
  logic ctl_ready;
  logic [2:0] paddr;
  logic [7:0] mreg [8];
  logic [15:0] pri_q[$], dac_q[$], sec_q[$];
  int err_total, checked, seed;

  csfp_link_if csfp_link_if_inst ();
  always #50 sys_clk = ~sys_clk;

  csfp_dev csfp_dev_inst (.sys_clk_i(sys_clk), .srst_i(srst), .sclk_i(csfp_link_if_inst.sclk),
    .master_sel_i(ms_sel), .frame_mode_sel_lo_i(mode_lo), .frame_mode_sel_hi_i(mode_hi),
    .power_down_n_i(pd_n), .adc_sample_i(adc_in), .adc_valid_i(adc_in_valid),
    .dac_sample_o(dac_out), .dac_valid_o(dac_out_valid), .lnk(csfp_link_if_inst));
  csfp_host csfp_host_inst (.sys_clk_i(sys_clk), .srst_i(srst), .sclk_i(csfp_link_if_inst.sclk),
    .host_master_i(~ms_sel), .frame_large_i(mode_hi), .dac_sample_i(dac_in),
    .dac_valid_i(dac_in_valid), .adc_sample_o(adc_out), .adc_sec_o(adc_out_sec),
    .adc_valid_o(adc_out_valid), .ctl_word_i(ctl_word), .ctl_valid_i(ctl_valid),
    .ctl_ready_o(ctl_ready), .ctl_done_o(), .lnk(csfp_link_if_inst));
  csfp_monitor csfp_monitor_inst (.sys_clk_i(sys_clk), .srst_i(srst), .power_down_n_i(pd_n),
    .sclk(csfp_link_if_inst.sclk), .fs(csfp_link_if_inst.fs), .frame_sync_delayed(csfp_link_if_inst.frame_sync_delayed),
    .dout_oe(csfp_link_if_inst.dout_oe), .dev_fs_o(csfp_link_if_inst.dev_fs_o),
    .dev_fs_oe(csfp_link_if_inst.dev_fs_oe), .host_fs_oe(csfp_link_if_inst.host_fs_oe),
    .dev_sclk_oe(csfp_link_if_inst.dev_sclk_oe),
    .host_sclk_oe(csfp_link_if_inst.host_sclk_oe));

  task automatic conclude();
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  // Empty queue yields unknown, so an unrequested result always mismatches
  always @(negedge sys_clk) begin
    if (arm && adc_out_valid === 1'b1 && adc_out_sec === 1'b1)
      chk16("sec_word", sec_q.size() ? sec_q.pop_front() : 16'hxxxx, adc_out);
    if (arm && adc_out_valid === 1'b1 && adc_out_sec !== 1'b1)
      chk16("pri_adc", pri_q.size() ? pri_q.pop_front() : 16'hxxxx, adc_out);
    if (arm && dac_out_valid === 1'b1)
      chk16("pri_dac", dac_q.size() ? dac_q.pop_front() : 16'hxxxx, dac_out);
  end

  task automatic wait_on(input bit pri);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!(pri ? adc_out_valid === 1'b1 && adc_out_sec === 1'b0 : ctl_ready === 1'b1)
      && n < 3000);
    if (n >= 3000) begin
      err_total++;
      conclude();
    end
  endtask

  // Results of frames already under way after wake-up are not predictable
  task automatic prime();
    arm = 1'b0;
    pri_q.delete();
    dac_q.delete();
    sec_q.delete();
    wait_on(1'b1);
    wait_on(1'b1);
    repeat (20) @(negedge sys_clk);
    arm = 1'b1;
  endtask

  task automatic frame(input bit ce, input logic [15:0] cw);
    adc_in = $random(seed);
    dac_in = $random(seed) & 16'hfffe;
    adc_in_valid = 1'b1;
    dac_in_valid = 1'b1;
    pri_q.push_back(adc_in);
    dac_q.push_back(dac_in | {15'h0000, ce});
    if (ce) begin
      chk1("ctl_ready", 1'b1, ctl_ready);
      ctl_word = cw;
      ctl_valid = 1'b1;
      sec_q.push_back(pend ? {ms_sel, 3'h1, paddr, 1'b0, mreg[paddr]} : {ms_sel, 15'h0000});
      pend = cw[12];
      paddr = cw[11:9];
      if (!cw[12] && cw[11:9] != 3'h0 && cw[11:9] < 3'h5) mreg[cw[11:9]] = cw[7:0];
    end
    @(negedge sys_clk);
    adc_in_valid = 1'b0;
    dac_in_valid = 1'b0;
    ctl_valid = 1'b0;
    wait_on(1'b1);
    if (ce) wait_on(1'b0);
  endtask

  task automatic phase(input logic ms, input logic big);
    logic [7:0] wd;
    wd = $random(seed);
    ms_sel = ms;
    mode_lo = ms ^ big;
    mode_hi = big;
    srst = 1'b1;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    pend = 1'b0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    prime();
    chk1("dev_sclk_oe", ms, csfp_link_if_inst.dev_sclk_oe);
    frame(1'b1, 16'h1400);
    frame(1'b1, {8'h04, wd});
    frame(1'b1, 16'h1400);
    frame(1'b1, 16'h0000);
    frame(1'b0, 16'h0000);
    arm = 1'b0;
    pd_n = 1'b0;
    repeat (40) @(negedge sys_clk);
    pd_n = 1'b1;
    prime();
    frame(1'b1, 16'h1400);
    frame(1'b1, 16'h0000);
    frame(1'b0, 16'h0000);
  endtask

  initial begin
    seed = 32'hea52f8f9;
    err_total = 0;
    checked = 0;
    arm = 1'b0;
    srst = 1'b1;
    ms_sel = 1'b1;
    mode_lo = 1'b0;
    mode_hi = 1'b0;
    pd_n = 1'b1;
    adc_in = 16'h0000;
    dac_in = 16'h0000;
    adc_in_valid = 1'b0;
    dac_in_valid = 1'b0;
    ctl_word = 16'h0000;
    ctl_valid = 1'b0;
    pend = 1'b0;
    paddr = 3'h0;
    @(negedge sys_clk);
    for (int p = 0; p < 4; p++) phase(p[0], p[1]);
    conclude();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
